/* pfm_assertions.sv */
// Purpose: Checker of pad routing against shadowed select registers
// Assumes: A write lands on the same edge that bvalid rises
// Notes: Wakeup register is not shadowed, strap capture can rewrite it
`timescale 1ns/1ps
`default_nettype none
`include "pfm_params.svh"
module pfm_assertions #(
  parameter int NUM_PINS = 42,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe,
  input wire logic [NUM_PINS-1:0] alt1_out,
  input wire logic [NUM_PINS-1:0] alt1_oe,
  input wire logic [NUM_PINS-1:0] alt2_out,
  input wire logic [NUM_PINS-1:0] alt2_oe,
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe
);
  logic [ADDR_W-1:0] adr_q;
  logic [7:0] dat_q, fan_q, misc_q, game_q, fan2_q;
  logic stb_q, bv_q, ok1_q, ok2_q;
  logic [NUM_PINS-1:0] go_q, ge_q, a1o_q, a1e_q, a2o_q, a2e_q;
  wire logic ok = ok1_q && ok2_q;
  ////////////////////////////////////////
  // Shadow lags the register by one edge, which lines it up with the pad flops
  always_ff @(posedge aclk) begin
    ok1_q <= aresetn;
    ok2_q <= ok1_q;
    {go_q, ge_q, a1o_q, a1e_q} <= {gpio_out, gpio_oe, alt1_out, alt1_oe};
    {a2o_q, a2e_q} <= {alt2_out, alt2_oe};
    bv_q <= s_axil_bvalid;
    if (s_axil_awvalid && s_axil_awready) adr_q <= s_axil_awaddr;
    if (s_axil_wvalid && s_axil_wready) {stb_q, dat_q} <= {s_axil_wstrb[0], s_axil_wdata[7:0]};
    if (!aresetn) begin
      {fan_q, misc_q, game_q, fan2_q} <= {`PFM_RST_FAN_KBD, `PFM_RST_MISC, `PFM_RST_GAME,
        `PFM_RST_FAN2};
    end else if (s_axil_bvalid && !bv_q && stb_q && s_axil_bresp == 2'h0) begin
      if (adr_q == ADDR_W'(`PFM_OFF_FAN_KBD)) fan_q <= dat_q;
      if (adr_q == ADDR_W'(`PFM_OFF_MISC)) misc_q <= dat_q;
      if (adr_q == ADDR_W'(`PFM_OFF_GAME)) game_q <= dat_q;
      if (adr_q == ADDR_W'(`PFM_OFF_FAN2)) fan2_q <= dat_q;
    end
  end
  function automatic logic [1:0] pv(input int p, input logic [1:0] c);
    if (c == 2'h1) return {a1o_q[p], a1e_q[p]};
    if (c == 2'h2) return {a2o_q[p], a2e_q[p]};
    return {go_q[p], ge_q[p]};
  endfunction
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  property p_fan_pwm; ok |-> {pad_out[0], pad_oe[0]} == pv(0, fan_q[1:0]); endproperty
  a_fan_pwm: assert property (p_fan_pwm) else $error("pad 0 source wrong");
  property p_fan_one; ok |-> pad_out[6:1] == ((fan_q[7:2] & a1o_q[6:1]) | (~fan_q[7:2] & go_q[6:1])); endproperty
  a_fan_one: assert property (p_fan_one) else $error("pads 1 to 6 source wrong");
  property p_kbd_rst; ok |-> {pad_out[7], pad_oe[7]} == pv(7, {1'h0, misc_q[0]}); endproperty
  a_kbd_rst: assert property (p_kbd_rst) else $error("pad 7 source wrong");
  property p_flop; ok |-> {pad_out[28], pad_oe[28]} == pv(28, game_q[1:0]); endproperty
  a_flop: assert property (p_flop) else $error("pad 28 source wrong");
  property p_drv; ok |-> {pad_out[29], pad_oe[29]} == pv(29, game_q[3:2]); endproperty
  a_drv: assert property (p_drv) else $error("pad 29 source wrong");
  property p_kbd16; ok |-> {pad_out[40], pad_oe[40]} == pv(40, game_q[7:6]); endproperty
  a_kbd16: assert property (p_kbd16) else $error("pad 40 source wrong");
  property p_joy; (ok && game_q[4]) [*2] |-> pad_oe[37:30] == a1e_q[37:30]; endproperty
  a_joy: assert property (p_joy) else $error("joystick pads not alternate");
  property p_midi; ok |-> pad_out[39:38] == (game_q[5] ? $past(alt1_out[39:38]) : $past(gpio_out[39:38])); endproperty
  a_midi: assert property (p_midi) else $error("midi pads source wrong");
  property p_tach; ok |-> {pad_out[41], pad_oe[41]} == pv(41, (fan2_q[1:0] == 2'h2) ? 2'h2 : 2'h0); endproperty
  a_tach: assert property (p_tach) else $error("pad 41 source wrong");
endmodule
`default_nettype wire

/* pfm_params.svh */
// Purpose: Constants of the pin function multiplexer
// Assumes: Included by the package, the pin mux, the checker and the bench
// Notes: Offsets are byte addresses on the register bus
`ifndef PFM_PARAMS_SVH
`define PFM_PARAMS_SVH

`define PFM_NUM_PINS 42
`define PFM_AW 5

`define PFM_OFF_FAN_KBD 5'h00
`define PFM_OFF_MISC 5'h04
`define PFM_OFF_WAKEUP 5'h08
`define PFM_OFF_SENSOR 5'h0C
`define PFM_OFF_GAME 5'h10
`define PFM_OFF_FAN2 5'h14
`define PFM_OFF_STATUS 5'h18

`define PFM_RST_FAN_KBD 8'h00
`define PFM_RST_MISC 8'h03
`define PFM_RST_WAKEUP 8'h00
`define PFM_RST_SENSOR 8'h00
`define PFM_RST_GAME 8'h00
`define PFM_RST_FAN2 8'h00
`define PFM_FAN2_MASK 8'h03

`define PFM_WAKE_FIRST_LED_OUT_LSB 1
`define PFM_WAKE_SECOND_LED_OUT_BIT 3
`define PFM_WAKE_RING_LSB 4
`define PFM_WAKE_CHAS_BIT 6
`define PFM_WAKE_PWR_BIT 7
`define PFM_SENS_TS_BIT 6
`define PFM_GAME_FLOP_LSB 0
`define PFM_GAME_DRV_LSB 2
`define PFM_GAME_JOY_BIT 4
`define PFM_GAME_MIDI_BIT 5
`define PFM_GAME_KBD_LSB 6

`define PFM_STRAP_SETTLE 2'h3
`define PFM_RESP_OKAY 2'h0
`define PFM_RESP_SLVERR 2'h2

`endif

/* pfm_pin_cell.sv */
// Purpose: One multiplexed pad: routes GPIO or one of two alternates
// Assumes: Select code 11 is reserved and behaves as GPIO
// Notes: Pad input is synchronised; pad output and enable are registered
`timescale 1ns/1ps
`default_nettype none

module pfm_pin_cell (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pfm_pkg::pfm_sel_e sel,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic gpio_in,
  input wire logic alt1_out,
  input wire logic alt1_oe,
  output logic alt1_in,
  input wire logic alt2_out,
  input wire logic alt2_oe,
  output logic alt2_in,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe
);
  import pfm_pkg::*;

  pfm_cell_s c_q;
  pfm_cell_s c_d;

  always_comb begin
    c_d = c_q;
    c_d.s1 = pad_in;
    c_d.s2 = c_q.s1;
    case (sel)
      PFM_SEL_ALT1: begin
        c_d.out = alt1_out;
        c_d.oe = alt1_oe;
      end
      PFM_SEL_ALT2: begin
        c_d.out = alt2_out;
        c_d.oe = alt2_oe;
      end
      default: begin
        c_d.out = gpio_out;
        c_d.oe = gpio_oe;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  // Unselected functions see a quiet low rather than the pad
  assign gpio_in = (sel == PFM_SEL_GPIO || sel == PFM_SEL_RSVD) ? c_q.s2 : 1'b0;
  assign alt1_in = (sel == PFM_SEL_ALT1) ? c_q.s2 : 1'b0;
  assign alt2_in = (sel == PFM_SEL_ALT2) ? c_q.s2 : 1'b0;
  assign pad_out = c_q.out;
  assign pad_oe = c_q.oe;

endmodule

`default_nettype wire

/* pfm_pin_mux.sv */
// Purpose: Pin function multiplexer with its select registers on AXI4-Lite
// Assumes: Peripherals and GPIO sit outside; straps settle before reset ends
// Notes: Pin index map is given per pin in the select decode below
//
// Behaviour
// - fan_kbd_pin_select[1:0]: 00 GPIO, 01 third fan PWM, 10 chassis lock.
// - wakeup_led_pin_select[2:1]: 00 GPIO, 01 first LED, 10 second over-temp.
// - wakeup_led_pin_select[3] picks second LED; initial value from straps.
// - wakeup_led_pin_select[5:4]: 00 GPIO, 01 ring input, 10 alarm output.
// - wakeup_led_pin_select[7] swaps four power pins to standby GP and aux.
// - game_midi_pin_select[1:0]: 00 GPIO, 01 second floppy motor, 10 IR line 2.
// - game_midi_pin_select[3:2]: 00 GPIO, 01 second drive select, 10 IR line 3.
// - game_midi_pin_select[7:6]: 00 GPIO, 01 keyboard line 16, 10 IR line 1.
// - fan2_pin_select[1:0]: 00 GPIO, 10 third fan tachometer input.
// - Straps sampled at standby power-up set LED and power pin selection.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

`include "pfm_params.svh"

module pfm_pin_mux #(
  parameter int NUM_PINS = `PFM_NUM_PINS,
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic pin_select_strap_a,
  input wire logic pin_select_strap_b,
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe,
  output logic [NUM_PINS-1:0] gpio_in,
  input wire logic [NUM_PINS-1:0] alt1_out,
  input wire logic [NUM_PINS-1:0] alt1_oe,
  output logic [NUM_PINS-1:0] alt1_in,
  input wire logic [NUM_PINS-1:0] alt2_out,
  input wire logic [NUM_PINS-1:0] alt2_oe,
  output logic [NUM_PINS-1:0] alt2_in,
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out,
  output logic [NUM_PINS-1:0] pad_oe
);
  import pfm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (NUM_PINS != `PFM_NUM_PINS) begin : g_bad_pins
    $error("NUM_PINS must match the fixed pin map");
  end
  if (ADDR_W < `PFM_AW) begin : g_bad_aw
    $error("ADDR_W too small for the register map");
  end
  // Select fields must stay inside their 8-bit registers
  if (`PFM_WAKE_RING_LSB > 6 || `PFM_GAME_KBD_LSB > 6) begin : g_bad_field
    $error("Select field lies outside its register");
  end
  // The synchroniser needs two edges before the straps may be captured
  if (`PFM_STRAP_SETTLE < 2) begin : g_bad_settle
    $error("Strap settle count shorter than the synchroniser");
  end

  localparam pfm_state_s ST_RST = '{
    fan_kbd: `PFM_RST_FAN_KBD,
    // Keyboard reset and gate A20 start on their alternates
    misc: `PFM_RST_MISC,
    wakeup: `PFM_RST_WAKEUP,
    sensor: `PFM_RST_SENSOR,
    game: `PFM_RST_GAME,
    fan2: `PFM_RST_FAN2,
    default: '0
  };

  pfm_state_s s_q;
  pfm_state_s s_d;
  pfm_sel_e sel [NUM_PINS];

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic pfm_sel_e one_bit(input logic b);
    return b ? PFM_SEL_ALT1 : PFM_SEL_GPIO;
  endfunction

  function automatic logic addr_hi(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] m;
    m = a >> `PFM_AW;
    return |m;
  endfunction

  // Only byte lane 0 carries data; upper lanes are accepted and ignored
  function automatic logic [8:0] rd_reg(input pfm_state_s s, input logic [`PFM_AW-1:0] a);
    case (a)
      `PFM_OFF_FAN_KBD: return {1'b1, s.fan_kbd};
      `PFM_OFF_MISC: return {1'b1, s.misc};
      `PFM_OFF_WAKEUP: return {1'b1, s.wakeup};
      `PFM_OFF_SENSOR: return {1'b1, s.sensor};
      `PFM_OFF_GAME: return {1'b1, s.game};
      `PFM_OFF_FAN2: return {1'b1, s.fan2};
      `PFM_OFF_STATUS: return {1'b1, 5'h00, s.strap_done, s.strap_val};
      default: return 9'h000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus and strap capture
  // A write answers the cycle after both halves are held, a read the cycle
  // after its address is taken; one of each may be in flight.

  always_comb begin
    logic hit;
    logic [8:0] rd;
    hit = 1'b0;
    rd = 9'h000;
    s_d = s_q;

    // Strap synchroniser: first stage feeds only the second
    s_d.strap_s1 = {pin_select_strap_b, pin_select_strap_a};
    s_d.strap_s2 = s_q.strap_s1;

    // Address and data may arrive in either order
    if (s_axil_awvalid && s_axil_awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axil_awaddr[`PFM_AW-1:0];
      s_d.aw_hi = addr_hi(s_axil_awaddr);
    end
    if (s_axil_wvalid && s_axil_wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axil_wdata[7:0];
      s_d.wstrb0 = s_axil_wstrb[0];
    end

    if (s_q.bvalid && s_axil_bready) begin
      s_d.bvalid = 1'b0;
    end

    if (s_d.aw_have && s_d.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      hit = !s_d.aw_hi;
      if (hit && s_d.wstrb0) begin
        case (s_d.awaddr)
          `PFM_OFF_FAN_KBD: s_d.fan_kbd = s_d.wdata;
          `PFM_OFF_MISC: s_d.misc = s_d.wdata;
          `PFM_OFF_WAKEUP: s_d.wakeup = s_d.wdata;
          `PFM_OFF_SENSOR: s_d.sensor = s_d.wdata;
          `PFM_OFF_GAME: s_d.game = s_d.wdata;
          `PFM_OFF_FAN2: s_d.fan2 = s_d.wdata & `PFM_FAN2_MASK;
          `PFM_OFF_STATUS: s_d.fan2 = s_d.fan2;
          default: hit = 1'b0;
        endcase
      end else if (hit) begin
        case (s_d.awaddr)
          `PFM_OFF_FAN_KBD, `PFM_OFF_MISC, `PFM_OFF_WAKEUP,
          `PFM_OFF_SENSOR, `PFM_OFF_GAME, `PFM_OFF_FAN2,
          `PFM_OFF_STATUS: hit = 1'b1;
          default: hit = 1'b0;
        endcase
      end
      s_d.bresp = hit ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
    end

    if (s_q.rvalid && s_axil_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axil_arvalid && s_axil_arready) begin
      rd = addr_hi(s_axil_araddr) ? 9'h000 : rd_reg(s_q, s_axil_araddr[`PFM_AW-1:0]);
      s_d.rvalid = 1'b1;
      s_d.rdata = rd[7:0];
      s_d.rresp = rd[8] ? `PFM_RESP_OKAY : `PFM_RESP_SLVERR;
    end

    // One-time capture of the straps once the synchroniser has filled;
    // it overrides a software write landing in the same cycle.
    if (!s_q.strap_done) begin
      s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      if (s_q.strap_cnt == `PFM_STRAP_SETTLE) begin
        s_d.strap_done = 1'b1;
        s_d.strap_val = s_q.strap_s2;
        s_d.wakeup[`PFM_WAKE_SECOND_LED_OUT_BIT] = s_q.strap_s2[0];
        s_d.wakeup[`PFM_WAKE_FIRST_LED_OUT_LSB +: 2] = {1'b0, s_q.strap_s2[0]};
        s_d.wakeup[`PFM_WAKE_PWR_BIT] = s_q.strap_s2[1];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axil_awready = !s_q.aw_have && !s_q.bvalid;
  assign s_axil_wready = !s_q.w_have && !s_q.bvalid;
  assign s_axil_bvalid = s_q.bvalid;
  assign s_axil_bresp = s_q.bresp;
  assign s_axil_arready = !s_q.rvalid;
  assign s_axil_rvalid = s_q.rvalid;
  assign s_axil_rdata = {24'h0000_00, s_q.rdata};
  assign s_axil_rresp = s_q.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Select decode, one entry per pad index.
  // Shared alternates are not arbitrated here: software keeps them unique.

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_sel
    case (p)
      // third_fan_pwm_out / chassis_lock_out; 11 falls back to GPIO
      0: begin : g_fan_pwm
        assign sel[p] = pfm_sel_e'(s_q.fan_kbd[1:0]);
      end
      // Fan tach/PWM pairs and two keyboard lines
      1, 2, 3, 4, 5, 6: begin : g_fan_kbd
        assign sel[p] = one_bit(s_q.fan_kbd[p+1]);
      end
      // keyboard_reset_out and gate_a20_out are alt1, reset value 1
      7, 8, 9: begin : g_misc_low
        assign sel[p] = one_bit(s_q.misc[p-7]);
      end
      // Single wake-up register pin
      10: begin : g_wake_single
        assign sel[p] = one_bit(s_q.wakeup[0]);
      end
      // first_led_out / second_overtemp_out
      11: begin : g_first_led_out
        assign sel[p] = pfm_sel_e'(s_q.wakeup[`PFM_WAKE_FIRST_LED_OUT_LSB +: 2]);
      end
      // second_led_out
      12: begin : g_second_led_out
        assign sel[p] = one_bit(s_q.wakeup[`PFM_WAKE_SECOND_LED_OUT_BIT]);
      end
      // Ring wake input / alarm output
      13: begin : g_ring
        assign sel[p] = pfm_sel_e'(s_q.wakeup[`PFM_WAKE_RING_LSB +: 2]);
      end
      // Chassis intrusion output
      14: begin : g_chassis
        assign sel[p] = one_bit(s_q.wakeup[`PFM_WAKE_CHAS_BIT]);
      end
      // alt1 = power_button_out, power_supply_on_out, power_button_in,
      // sleep_state5_in (bit clear); GPIO side = standby_gp_out_a,
      // standby_gp_out_b, standby_gp_in, auxiliary_in
      15, 16, 17, 18: begin : g_power
        assign sel[p] = one_bit(!s_q.wakeup[`PFM_WAKE_PWR_BIT]);
      end
      // Diode inputs on GPIO side, thermistor inputs on alt1
      19, 20, 21: begin : g_thermal
        assign sel[p] = one_bit(s_q.sensor[`PFM_SENS_TS_BIT]);
      end
      // Both bus lines follow one bit, so they cannot be split
      22, 23: begin : g_misc_pair
        assign sel[p] = one_bit(s_q.misc[5]);
      end
      // Two output singles
      24, 25: begin : g_misc_high
        assign sel[p] = one_bit(s_q.misc[p-18]);
      end
      // Infrared receive inputs
      26, 27: begin : g_infrared_in
        assign sel[p] = one_bit(s_q.sensor[p-26]);
      end
      // second_floppy_motor_out / infrared_select_line2
      28: begin : g_floppy
        assign sel[p] = pfm_sel_e'(s_q.game[`PFM_GAME_FLOP_LSB +: 2]);
      end
      // second_drive_select_out / infrared_select_line3
      29: begin : g_drive
        assign sel[p] = pfm_sel_e'(s_q.game[`PFM_GAME_DRV_LSB +: 2]);
      end
      // Joystick axes and buttons
      30, 31, 32, 33, 34, 35, 36, 37: begin : g_joystick
        assign sel[p] = one_bit(s_q.game[`PFM_GAME_JOY_BIT]);
      end
      // MIDI transmit and receive
      38, 39: begin : g_midi
        assign sel[p] = one_bit(s_q.game[`PFM_GAME_MIDI_BIT]);
      end
      // keyboard_port_line16 / infrared_select_line1
      40: begin : g_kbd16
        assign sel[p] = pfm_sel_e'(s_q.game[`PFM_GAME_KBD_LSB +: 2]);
      end
      // third_fan_tach_in sits on alt2; code 01 keeps GPIO
      41: begin : g_tach
        assign sel[p] = (s_q.fan2[1:0] == 2'b10) ? PFM_SEL_ALT2 : PFM_SEL_GPIO;
      end
      // Unreachable while the pad count is fixed
      default: begin : g_none
        assign sel[p] = PFM_SEL_GPIO;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad cells
  // Each cell registers its drive, so a select change shows one edge later

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pad
    pfm_pin_cell u_cell (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(sel[p]),
      .gpio_out(gpio_out[p]),
      .gpio_oe(gpio_oe[p]),
      .gpio_in(gpio_in[p]),
      .alt1_out(alt1_out[p]),
      .alt1_oe(alt1_oe[p]),
      .alt1_in(alt1_in[p]),
      .alt2_out(alt2_out[p]),
      .alt2_oe(alt2_oe[p]),
      .alt2_in(alt2_in[p]),
      .pad_in(pad_in[p]),
      .pad_out(pad_out[p]),
      .pad_oe(pad_oe[p])
    );
  end

endmodule

`default_nettype wire

/* pfm_pkg.sv */
// Purpose: Types of the pin function multiplexer
// Assumes: pfm_params.svh gives the widths
// Notes: All module state is carried in these structs
`include "pfm_params.svh"

package pfm_pkg;

  typedef enum logic [1:0] {
    PFM_SEL_GPIO = 2'b00,
    PFM_SEL_ALT1 = 2'b01,
    PFM_SEL_ALT2 = 2'b10,
    PFM_SEL_RSVD = 2'b11
  } pfm_sel_e;

  typedef struct packed {
    logic s1;
    logic s2;
    logic out;
    logic oe;
  } pfm_cell_s;

  typedef struct packed {
    logic aw_have;
    logic aw_hi;
    logic [`PFM_AW-1:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] fan_kbd;
    logic [7:0] misc;
    logic [7:0] wakeup;
    logic [7:0] sensor;
    logic [7:0] game;
    logic [7:0] fan2;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [1:0] strap_val;
  } pfm_state_s;

endpackage

/* pfm_tb.sv */
// Purpose: Self-checking bench of the pin function multiplexer
// Assumes: Straps held steady through each reset
// Notes: Outputs are driven to three distinct out/oe pairs so each source shows
`timescale 1ns/1ps
`default_nettype none
`include "pfm_params.svh"
module testbench;
  localparam int NP = `PFM_NUM_PINS;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0000_0000, s_axil_rdata, rd;
  logic [3:0] s_axil_wstrb = 4'h0;
  logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
  logic s_axil_arvalid = 1'h0, s_axil_rready = 1'h0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp, rsp;
  logic pin_select_strap_a = 1'h1, pin_select_strap_b = 1'h0;
  logic [NP-1:0] gpio_out = '1, gpio_oe = '0, alt1_out = '0, alt1_oe = '1, alt2_out = '1;
  logic [NP-1:0] alt2_oe = '1, pad_in = '1, gpio_in, alt1_in, alt2_in, pad_out, pad_oe;
  int fails = 0, total_checks = 0;
  // Entry: address, data, pad, source (0 GPIO, 1 first alternate, 2 second)
  logic [31:0] tbl [24] = '{32'h0001_0001, 32'h0002_0002, 32'h0003_0000, 32'h0004_0101,
    32'h0080_0601, 32'h0400_0700, 32'h0420_1601, 32'h0804_0B02, 32'h0810_0D01, 32'h0820_0D02,
    32'h0880_0F00, 32'h0800_1201, 32'h0C40_1301, 32'h1001_1C01, 32'h1002_1C02, 32'h1004_1D01,
    32'h1008_1D02, 32'h1010_2501, 32'h1020_2701, 32'h1040_2801, 32'h1080_2802, 32'h10C0_2800,
    32'h1402_2902, 32'h14FF_2900};
  always #5 aclk = ~aclk;
  pfm_pin_mux i_dut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
    .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
    .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
    .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .pin_select_strap_a, .pin_select_strap_b,
    .gpio_out, .gpio_oe, .gpio_in, .alt1_out, .alt1_oe, .alt1_in, .alt2_out, .alt2_oe,
    .alt2_in, .pad_in, .pad_out, .pad_oe);
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    fails++;
    $display("Error at %0t: no answer in time", $time);
    wrap_up();
  endtask
  task automatic do_reset();
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
  endtask
  // Valid and payload stay up until their own handshake edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    @(posedge aclk);
    {s_axil_awaddr, s_axil_wdata, s_axil_wstrb} <= {a, 24'h0, d, s};
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 1'h0;
      if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 1'h0;
      n++;
      if (n > 50) hang();
    end while (!s_axil_bvalid);
    rsp = s_axil_bresp;
    s_axil_bready <= 1'h0;
  endtask
  task automatic rdreg(input logic [7:0] a);
    int n;
    @(posedge aclk);
    {s_axil_araddr, s_axil_arvalid, s_axil_rready} <= {a, 2'h3};
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 1'h0;
      n++;
      if (n > 50) hang();
    end while (!s_axil_rvalid);
    {rd, rsp} = {s_axil_rdata, s_axil_rresp};
    s_axil_rready <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    rdreg(a);
    chk(rd, {24'h0, e});
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  task automatic pchk(input int p, input logic [7:0] s);
    logic [4:0] e;
    e = (s == 8'h01) ? {alt1_out[p], alt1_oe[p], 3'h2} :
        (s == 8'h02) ? {alt2_out[p], alt2_oe[p], 3'h1} : {gpio_out[p], gpio_oe[p], 3'h4};
    e[2:0] = e[2:0] & {3{pad_in[p]}};
    chk({27'h0, pad_out[p], pad_oe[p], gpio_in[p], alt1_in[p], alt2_in[p]}, {27'h0, e});
  endtask
  task automatic strap_run(input logic [7:0] st, input logic [7:0] wk, input logic [7:0] s);
    int n;
    n = 0;
    do begin
      rdreg(8'h18);
      n++;
      if (n > 20) hang();
    end while (rd[2] !== 1'h1);
    chk(rd, {24'h0, st});
    rchk(8'h08, wk, 2'h0);
    pchk(12, s);
    pchk(15, (s == 8'h01) ? 8'h01 : 8'h00);
    pchk(18, (s == 8'h01) ? 8'h01 : 8'h00);
    $display("Test straps done");
  endtask
  ////////////////////////////////////////
  initial begin
    logic [31:0] t;
    do_reset();
    strap_run(8'h05, 8'h0A, 8'h01);
    pchk(11, 8'h01);
    foreach (tbl[i]) rchk(tbl[i][31:24], (tbl[i][31:24] == 8'h04) ? 8'h03 :
      (tbl[i][31:24] == 8'h08) ? 8'h0A : 8'h00, 2'h0);
    pchk(7, 8'h01);
    pchk(8, 8'h01);
    $display("Test reset values done");
    for (int pass = 0; pass < 2; pass++) begin
      if (pass == 1) begin
        {gpio_out, alt1_out, alt2_out, pad_in} <= {{NP{1'h0}}, {NP{1'h1}}, {NP{1'h0}}, {NP{1'h0}}};
      end
      // One shared alternate enabled at a time
      foreach (tbl[i]) begin
        t = tbl[i];
        wr(t[31:24], t[23:16], 4'hF);
        chk({30'h0, rsp}, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        pchk(t[15:8], t[7:0]);
        rchk(t[31:24], t[23:16] & ((t[31:24] == 8'h14) ? `PFM_FAN2_MASK : 8'hFF), 2'h0);
      end
      $display("Test routing pass %0d done", pass);
    end
    foreach (tbl[i]) if (i < 3) begin
      t = {8'h1C, 8'h11, 8'h30, 8'h00} >> (8 * (3 - i));
      wr(t[7:0], 8'h00, 4'hF);
      chk({30'h0, rsp}, 32'h0000_0002);
      rchk(t[7:0], 8'h00, 2'h2);
    end
    wr(8'h10, 8'h55, 4'h0);
    rchk(8'h10, 8'hC0, 2'h0);
    wr(8'h18, 8'h00, 4'hF);
    rchk(8'h18, 8'h05, 2'h0);
    $display("Test refusals done");
    {pin_select_strap_a, pin_select_strap_b} <= 2'h1;
    do_reset();
    strap_run(8'h06, 8'h80, 8'h00);
    wrap_up();
  end
endmodule
bind pfm_pin_mux pfm_assertions #(.NUM_PINS(NUM_PINS), .ADDR_W(ADDR_W)) i_chk (.aclk, .aresetn,
  .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
  .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .gpio_out, .gpio_oe,
  .alt1_out, .alt1_oe, .alt2_out, .alt2_oe, .pad_out, .pad_oe);
`default_nettype wire
